// file: rtl/io_port_regs.svh
// widths, direction encoding and reset values of the io port block
// assumes inclusion from the package and the port module only
`ifndef IO_PORT_REGS_SVH
`define IO_PORT_REGS_SVH

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define PORT_WIDTH 8
`define LATCH_RESET 8'h00
// direction bit: 1 = input (buffer off), 0 = output
`define DIR_INPUT 1'b1
`define DIR_OUTPUT 1'b0
`define DIR_RESET 8'hFF
// shared analog group: 1 = analog input mode
`define ANALOG_RESET 8'hFF

`endif

// file: rtl/io_port_pkg.sv
// types shared by the io port block
// assumes io_port_regs.svh sits beside it
package io_port_pkg;
`include "io_port_regs.svh"

    // ----------------------------------------
    // cpu access kinds
    // ----------------------------------------
    typedef enum logic [1:0] {
        ACC_NONE  = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_READ  = 2'b10,
        ACC_RMW   = 2'b11
    } access_e;

    typedef enum logic [1:0] {
        TGT_LATCH  = 2'b00,
        TGT_DIR    = 2'b01,
        TGT_ANALOG = 2'b10
    } target_e;

    typedef struct packed {
        access_e acc;
        target_e tgt;
        logic [`PORT_WIDTH-1:0] wdata;
    } cpu_req_s;

    typedef struct packed {
        logic valid;
        logic [`PORT_WIDTH-1:0] rdata;
    } cpu_rsp_s;

    typedef struct packed {
        logic [`PORT_WIDTH-1:0] out;
        logic [`PORT_WIDTH-1:0] oe;
    } pin_drive_s;

endpackage : io_port_pkg

// file: rtl/io_port_latch_logic.sv
// What this block does
// - output-mode write loads latch; buffer drives latch onto the pin
// - latch holds its value until the next write, in either mode
// - reset clears every output latch bit to zero
// - input-mode write updates latch, buffer stays off, pin unaffected
// - output-mode read returns the latch, not the pin
// - input-mode read returns the synchronised pin level
// - a plain read never changes the latch
// - output-mode rmw: operand from latch, result to latch and pin
// - input-mode rmw: operand from pin, result to latch, pin undriven
// - shared analog pins start in analog input mode after reset
//
// one 8-bit port: latch, direction, analog select and pin sampling
// assumes cpu requests on clk_i; pins arrive asynchronously
`timescale 1ns/1ps
`include "io_port_regs.svh"

module io_port_latch_logic
    import io_port_pkg::*;
#(
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire cpu_req_s req_i,
    input wire logic [WIDTH-1:0] pin_i,
    output cpu_rsp_s rsp_o,
    output pin_drive_s pin_o,
    output logic [WIDTH-1:0] analog_sel_o
);

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    // one filter per pin; a read sees a pin change four edges after it
    logic [WIDTH-1:0] pin_level_q;

    for (genvar g = 0; g < WIDTH; g++) begin : g_pin
        pin_filter u_filter (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .raw_i(pin_i[g]),
            .level_o(pin_level_q[g])
        );
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;
    logic [WIDTH-1:0] analog_q;
    logic [WIDTH-1:0] analog_d;
    logic [WIDTH-1:0] read_view;
    logic [WIDTH-1:0] rdata_d;
    logic wr_dir;
    logic wr_analog;
    logic rd_any;

    // ----------------------------------------
    // access decode
    // ----------------------------------------
    // rmw on a mode register writes it and still raises a read response; target code 3 selects nothing
    always_comb begin
        wr_dir = 1'b0;
        wr_analog = 1'b0;
        if (req_i.acc == ACC_WRITE || req_i.acc == ACC_RMW) begin
            wr_dir = (req_i.tgt == TGT_DIR);
            wr_analog = (req_i.tgt == TGT_ANALOG);
        end
    end

    always_comb begin
        rd_any = (req_i.acc == ACC_READ || req_i.acc == ACC_RMW);
    end

    // next mode values; the pin drive is registered from these so it
    // switches on the same edge as the mode registers
    always_comb begin
        dir_d = dir_q;
        if (wr_dir) begin
            dir_d = req_i.wdata;
        end
    end

    always_comb begin
        analog_d = analog_q;
        if (wr_analog) begin
            analog_d = req_i.wdata;
        end
    end

    // per-bit read view: latch for output pins, pin level for input pins
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (dir_q[i] == `DIR_OUTPUT) begin
                read_view[i] = latch_q[i];
            end else begin
                read_view[i] = pin_level_q[i];
            end
        end
    end

    // rmw: the cpu supplies the result in wdata; operand was the read view
    always_comb begin
        latch_d = latch_q;
        if (req_i.tgt == TGT_LATCH) begin
            unique case (req_i.acc)
                ACC_WRITE: latch_d = req_i.wdata;
                ACC_RMW: latch_d = req_i.wdata;
                ACC_READ: latch_d = latch_q;
                ACC_NONE: latch_d = latch_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latch_q <= `LATCH_RESET;
        end else begin
            latch_q <= latch_d[WIDTH-1:0];
        end
    end

    // software owns direction; alternate functions rely on it being set first
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dir_q <= `DIR_RESET;
        end else begin
            dir_q <= dir_d;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            analog_q <= `ANALOG_RESET;
        end else begin
            analog_q <= analog_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // pin drive registered from the next state so it follows the latch
    // by the same edge; a pin in analog mode never drives
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_o <= '0;
        end else begin
            pin_o.out <= latch_d;
            pin_o.oe <= ~dir_d & ~analog_d;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            analog_sel_o <= `ANALOG_RESET;
        end else begin
            analog_sel_o <= analog_d;
        end
    end

    // read mux; an unused target code reads back the port view
    always_comb begin
        unique case (req_i.tgt)
            TGT_DIR: rdata_d = dir_q;
            TGT_ANALOG: rdata_d = analog_q;
            default: rdata_d = read_view;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.valid <= rd_any;
            rsp_o.rdata <= rdata_d;
        end
    end

endmodule : io_port_latch_logic

// ----------------------------------------
// per-pin input filter
// ----------------------------------------
// three flops against metastability; the level moves only once
// stages two and three agree, so a one-sample glitch is dropped
module pin_filter (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic raw_i,
    output logic level_o
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage1_q <= 1'h0;
            stage2_q <= 1'h0;
            stage3_q <= 1'h0;
        end else begin
            stage1_q <= raw_i;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_o <= 1'h0;
        end else if (stage2_q == stage3_q) begin
            level_o <= stage3_q;
        end
    end

endmodule : pin_filter

// file: test/io_port_sva.sv
// port checker for io_port_latch_logic
// assumes a bind from tb_top
`timescale 1ns/1ps
module io_port_sva
    import io_port_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire cpu_req_s req_i,
    input wire logic [WIDTH-1:0] pin_i,
    input wire cpu_rsp_s rsp_o,
    input wire pin_drive_s pin_o,
    input wire logic [WIDTH-1:0] analog_sel_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    wire to_latch = req_i.tgt == TGT_LATCH;
    // sync chain needs 4 edges; 6 leaves margin
    sequence s_pin_quiet;
        $stable(pin_i)[*6];
    endsequence
    sequence s_input_read;
        req_i.acc == ACC_READ && to_latch && pin_o.oe == '0 && analog_sel_o == '0;
    endsequence
    a_rsp_on: assert property (req_i.acc[1] |=> rsp_o.valid) else $error("no response");
    a_rsp_off: assert property (!req_i.acc[1] |=> !rsp_o.valid) else $error("stray response");
    a_write_out: assert property (req_i.acc == ACC_WRITE && to_latch |=> pin_o.out == $past(req_i.wdata))
        else $error("write not driven");
    a_rmw_out: assert property (req_i.acc == ACC_RMW && to_latch |=> pin_o.out == $past(req_i.wdata))
        else $error("rmw result lost");
    a_latch_hold: assert property (!(req_i.acc[0] && to_latch) |=> $stable(pin_o.out))
        else $error("latch moved");
    a_write_oe: assert property (req_i.acc == ACC_WRITE && to_latch && $past(req_i.tgt) == TGT_LATCH
        |=> $stable(pin_o.oe)) else $error("buffer moved");
    a_rmw_oe: assert property (req_i.acc == ACC_RMW && to_latch |=> $stable(pin_o.oe))
        else $error("rmw moved buffer");
    a_dir_drive: assert property (req_i.acc == ACC_WRITE && req_i.tgt == TGT_DIR
        |=> pin_o.oe == (~$past(req_i.wdata) & ~analog_sel_o)) else $error("direction not applied");
    a_analog_off: assert property ((pin_o.oe & analog_sel_o) == '0) else $error("analog pin driven");
    a_read_latch: assert property (req_i.acc == ACC_READ && to_latch
        |=> ((rsp_o.rdata ^ $past(pin_o.out)) & $past(pin_o.oe)) == '0) else $error("bad latch read");
    a_read_pin: assert property (s_pin_quiet ##0 s_input_read |=> rsp_o.rdata == $past(pin_i))
        else $error("bad pin read");
endmodule : io_port_sva

// file: test/board_model.sv
// board side of the port pins
// assumes the design's drive struct
`timescale 1ns/1ps
module board_model
    import io_port_pkg::*;
(
    input wire pin_drive_s drive_i,
    input wire logic [7:0] level_i,
    output logic [7:0] pin_lvl_o
);
    // driven pins win; the rest follow the board
    assign pin_lvl_o = (drive_i.oe & drive_i.out) | (~drive_i.oe & level_i);
endmodule : board_model

// file: test/tb_top.sv
// self-checking bench for io_port_latch_logic
// assumes board_model and io_port_sva
`timescale 1ns/1ps
module tb_top
    import io_port_pkg::*;
;
    logic clk_i = 0;
    logic rstn_i = 0;
    cpu_req_s req_i = '0;
    logic [7:0] board_lvl = 8'h00;
    logic [7:0] pin_lvl;
    cpu_rsp_s rsp_o;
    cpu_rsp_s rv;
    pin_drive_s pin_o;
    logic [7:0] analog_sel_o;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    io_port_latch_logic DUT (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .pin_i(pin_lvl),
        .rsp_o(rsp_o), .pin_o(pin_o), .analog_sel_o(analog_sel_o));
    board_model BRD (.drive_i(pin_o), .level_i(board_lvl), .pin_lvl_o(pin_lvl));
    initial forever #12.5 clk_i = ~clk_i;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle
    // response is captured just after the taking edge
    task cpu(input access_e a, input target_e t, input logic [7:0] d);
        req_i = '{acc: a, tgt: t, wdata: d};
        idle(1);
        rv = rsp_o;
        req_i.acc = ACC_NONE;
        idle(1);
    endtask : cpu
    task t_output;
        cpu(ACC_WRITE, TGT_ANALOG, 8'h00);
        cpu(ACC_WRITE, TGT_DIR, 8'h00);
        cpu(ACC_WRITE, TGT_LATCH, 8'hA5);
        chk(pin_o.out, 8'hA5);
        chk(pin_o.oe, 8'hFF);
        board_lvl = 8'hC3;
        cpu(ACC_READ, TGT_LATCH, 8'h00);
        chk(rv.rdata, 8'hA5);
        chk({7'h00, rv.valid}, 8'h01);
        cpu(ACC_RMW, TGT_LATCH, ~rv.rdata);
        chk(pin_lvl, 8'h5A);
        chk(pin_o.out, 8'h5A);
        $display("test output done");
    endtask : t_output
    task t_input;
        cpu(ACC_WRITE, TGT_DIR, 8'hFF);
        cpu(ACC_WRITE, TGT_LATCH, 8'h3C);
        chk(pin_o.out, 8'h3C);
        chk(pin_o.oe, 8'h00);
        board_lvl = 8'h81;
        idle(6);
        cpu(ACC_READ, TGT_LATCH, 8'h00);
        chk(rv.rdata, 8'h81);
        chk(pin_o.out, 8'h3C);
        cpu(ACC_RMW, TGT_LATCH, rv.rdata | 8'h0F);
        chk(pin_o.out, 8'h8F);
        chk(pin_lvl, 8'h81);
        cpu(ACC_WRITE, TGT_DIR, 8'h00);
        idle(1);
        chk(pin_lvl, 8'h8F);
        rstn_i = 0;
        idle(2);
        chk(pin_o.out, 8'h00);
        chk(analog_sel_o, 8'hFF);
        rstn_i = 1;
        $display("test input done");
    endtask : t_input
    // after the mid-run reset: analog mode keeps the buffer off, mode registers read back
    task t_mode;
        cpu(ACC_WRITE, TGT_DIR, 8'h00);
        chk(pin_o.oe, 8'h00);
        cpu(ACC_READ, TGT_DIR, 8'h00);
        chk(rv.rdata, 8'h00);
        cpu(ACC_READ, TGT_ANALOG, 8'h00);
        chk(rv.rdata, 8'hFF);
        cpu(ACC_RMW, TGT_ANALOG, 8'h0F);
        chk({7'h00, rv.valid}, 8'h01);
        chk(analog_sel_o, 8'h0F);
        chk(pin_o.oe, 8'hF0);
        cpu(ACC_WRITE, TGT_LATCH, 8'hFF);
        chk(pin_lvl, 8'hF1);
        $display("test mode done");
    endtask : t_mode
    task summarize;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            summarize;
        end
    end
    initial begin
        idle(2);
        rstn_i = 1;
        chk(pin_o.out, 8'h00);
        chk(analog_sel_o, 8'hFF);
        t_output;
        t_input;
        t_mode;
        summarize;
    end
endmodule : tb_top
bind io_port_latch_logic io_port_sva #(.WIDTH(WIDTH)) SVA (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i),
    .pin_i(pin_i), .rsp_o(rsp_o), .pin_o(pin_o), .analog_sel_o(analog_sel_o));
